/* File: logic/cpu_dec_params.svh */
// Constants for the opcode decode and bus-cycle sequencer
`ifndef CPU_DEC_PARAMS_SVH
`define CPU_DEC_PARAMS_SVH

`define OP_PREFIX 8'h9e
`define OP_XFER_SP 8'h94
`define OP_WAIT 8'h8f
`define OP_RTS 8'h81
`define VEC_PAGE 8'hff
`define VEC_RESET_LO 8'hfe
`define VEC_IRQ_LO 8'hfa
`define SP_RESET 16'h00ff
`define HX_RESET 16'h0000
`define PC_RESET 16'h0000

`endif

/* File: logic/cpu_dec_pkg.sv */
// Types shared by the opcode decode and bus-cycle sequencer
package cpu_dec_pkg;

	typedef enum logic [11:0] {
		S_OPC = 12'h001,
		S_OPR1 = 12'h002,
		S_OPR2 = 12'h004,
		S_ACC = 12'h008,
		S_FREE = 12'h010,
		S_HALT = 12'h020,
		S_PUSH_LO = 12'h040,
		S_PUSH_HI = 12'h080,
		S_VEC_HI = 12'h100,
		S_VEC_LO = 12'h200,
		S_POP_HI = 12'h400,
		S_POP_LO = 12'h800
	} state_t;

	typedef enum logic [3:0] {
		M_NONE, M_IMM8, M_IMM16, M_DIR, M_EXT, M_IX, M_IX_S, M_IX_L,
		M_IXP, M_IXOP, M_STK_S, M_STK_L, M_REL, M_MOVE
	} mode_t;

	typedef enum logic [2:0] {
		CYC_FREE, CYC_FETCH, CYC_READ, CYC_WRITE, CYC_PUSH, CYC_POP, CYC_VEC
	} cycle_t;

	typedef struct packed {
		logic ill;
		logic rel;
		mode_t mode;
	} dec_t;

endpackage

/* File: logic/opcode_sequencer.sv */
// Opcode decoder, address former and bus-cycle sequencer
`timescale 1ns/1ps
`include "cpu_dec_params.svh"
module opcode_sequencer #(
	parameter logic [15:0] SP_INIT = `SP_RESET
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// System bus
	input wire logic [7:0] bus_rdata,
	output logic [15:0] bus_addr_ff,
	output logic [7:0] bus_wdata_ff,
	output logic bus_we_ff,
	output cpu_dec_pkg::cycle_t bus_cycle_ff,
	// Interrupt pin and index load
	input wire logic irq_req,
	input wire logic hx_load,
	input wire logic [15:0] hx_value,
	// Decode results
	output logic [7:0] opcode_ff,
	output logic page2_ff,
	output cpu_dec_pkg::mode_t mode_ff,
	output logic [15:0] ea_ff,
	output logic ea_valid_ff,
	output logic [15:0] imm_ff,
	output logic imm_valid_ff,
	output logic [15:0] branch_target_ff,
	output logic branch_valid_ff,
	output logic [2:0] bit_num_ff,
	output logic bit_valid_ff,
	output logic [7:0] data_ff,
	output logic data_valid_ff,
	output logic illegal_ff,
	// Core state
	output logic halted_ff,
	output logic imask_ff,
	output logic [15:0] hx_ff,
	output logic [15:0] sp_ff
);

	cpu_dec_pkg::state_t st_ff, nxt_st;
	cpu_dec_pkg::cycle_t nxt_cyc;
	cpu_dec_pkg::mode_t cur_mode;
	cpu_dec_pkg::dec_t dec;
	logic [15:0] pc_ff, nxt_pc, pc_inc, nxt_addr, ea_now, opnd, rel_sext;
	logic [7:0] b1_ff, hold_hi_ff, nxt_wdata;
	logic [1:0] cnt_ff, dec_cnt;
	logic pfx_ff, rel_ff, irq_meta_ff, irq_sync_ff;
	logic in_opc, is_pfx, irq_take, fin, cur_rel, nxt_we, is_xfer, is_wait, is_rts;
	logic [7:0] cur_op;
	logic cur_pg2;

	function automatic cpu_dec_pkg::dec_t decode_op(input logic pg2, input logic [7:0] op);
		cpu_dec_pkg::dec_t d;
		logic [3:0] hi;
		logic [3:0] lo;
		hi = op[7:4];
		lo = op[3:0];
		d = '{ill: 1'b0, rel: 1'b0, mode: cpu_dec_pkg::M_NONE};
		if (!pg2)
		begin
			case (hi)
				4'h0: d = '{ill: 1'b0, rel: 1'b1, mode: cpu_dec_pkg::M_DIR};
				4'h1: d.mode = cpu_dec_pkg::M_DIR;
				4'h2: d = '{ill: 1'b0, rel: 1'b1, mode: cpu_dec_pkg::M_REL};
				4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
				begin
					d.rel = (lo == 4'h1) || (lo == 4'hb);
					if (hi == 4'h3)
						d.mode = cpu_dec_pkg::M_DIR;
					else if (hi == 4'h6)
						d.mode = (lo == 4'h1) ? cpu_dec_pkg::M_IXOP : cpu_dec_pkg::M_IX_S;
					else if (hi == 4'h7)
						d.mode = (lo == 4'h1) ? cpu_dec_pkg::M_IXP : cpu_dec_pkg::M_IX;
					else if (lo == 4'h1)
						d.mode = cpu_dec_pkg::M_IMM8;
					if (lo == 4'he)
						d.mode = cpu_dec_pkg::M_MOVE;
					case (op)
						8'h32, 8'h3e: d.mode = cpu_dec_pkg::M_EXT;
						8'h45, 8'h65: d.mode = cpu_dec_pkg::M_IMM16;
						8'h55, 8'h75: d.mode = cpu_dec_pkg::M_DIR;
						8'h62, 8'h72: d.mode = cpu_dec_pkg::M_NONE;
						default: ;
					endcase
				end
				4'h8: d.ill = (lo == 4'hd);
				4'h9:
				begin
					if (lo <= 4'h3)
						d = '{ill: 1'b0, rel: 1'b1, mode: cpu_dec_pkg::M_REL};
					else if (lo == 4'h6)
						d.mode = cpu_dec_pkg::M_EXT;
				end
				4'ha:
				begin
					d.mode = cpu_dec_pkg::M_IMM8;
					d.ill = (lo == 4'hc);
					if (lo == 4'hd)
						d = '{ill: 1'b0, rel: 1'b1, mode: cpu_dec_pkg::M_REL};
				end
				4'hb: d.mode = cpu_dec_pkg::M_DIR;
				4'hc: d.mode = cpu_dec_pkg::M_EXT;
				4'hd: d.mode = cpu_dec_pkg::M_IX_L;
				4'he: d.mode = cpu_dec_pkg::M_IX_S;
				default: d.mode = cpu_dec_pkg::M_IX;
			endcase
		end
		else
		begin
			// Second table, sparsely populated: anything unlisted is illegal
			d.ill = 1'b1;
			case (hi)
				4'h6:
				begin
					d.mode = cpu_dec_pkg::M_STK_S;
					d.ill = (lo == 4'h2) || (lo == 4'h5) || (lo == 4'he);
					d.rel = (lo == 4'h1) || (lo == 4'hb);
				end
				4'hd, 4'he:
				begin
					d.mode = (hi == 4'hd) ? cpu_dec_pkg::M_STK_L : cpu_dec_pkg::M_STK_S;
					d.ill = (lo == 4'hc) || (lo == 4'hd);
				end
				default: ;
			endcase
			case (op)
				8'hae: d = '{ill: 1'b0, rel: 1'b0, mode: cpu_dec_pkg::M_IX};
				8'hbe: d = '{ill: 1'b0, rel: 1'b0, mode: cpu_dec_pkg::M_IX_L};
				8'hce: d = '{ill: 1'b0, rel: 1'b0, mode: cpu_dec_pkg::M_IX_S};
				8'hf3, 8'hfe, 8'hff: d = '{ill: 1'b0, rel: 1'b0, mode: cpu_dec_pkg::M_STK_S};
				default: ;
			endcase
		end
		return d;
	endfunction

	function automatic logic [1:0] op_bytes(input cpu_dec_pkg::mode_t m, input logic [7:0] op);
		case (m)
			cpu_dec_pkg::M_IMM8, cpu_dec_pkg::M_DIR, cpu_dec_pkg::M_IX_S,
			cpu_dec_pkg::M_IXOP, cpu_dec_pkg::M_STK_S: op_bytes = 2'h1;
			cpu_dec_pkg::M_IMM16, cpu_dec_pkg::M_EXT, cpu_dec_pkg::M_IX_L,
			cpu_dec_pkg::M_STK_L: op_bytes = 2'h2;
			cpu_dec_pkg::M_MOVE: op_bytes = op[4] ? 2'h1 : 2'h2;
			default: op_bytes = 2'h0;
		endcase
	endfunction

	function automatic logic is_mem(input cpu_dec_pkg::mode_t m);
		is_mem = !(m inside {cpu_dec_pkg::M_NONE, cpu_dec_pkg::M_IMM8,
			cpu_dec_pkg::M_IMM16, cpu_dec_pkg::M_REL, cpu_dec_pkg::M_MOVE});
	endfunction

	function automatic logic [15:0] calc_ea(input cpu_dec_pkg::mode_t m,
		input logic [15:0] off, input logic [15:0] hx, input logic [15:0] sp);
		case (m)
			cpu_dec_pkg::M_DIR: calc_ea = {8'h00, off[7:0]};
			cpu_dec_pkg::M_EXT: calc_ea = off;
			cpu_dec_pkg::M_IX, cpu_dec_pkg::M_IXP: calc_ea = hx;
			cpu_dec_pkg::M_IX_S, cpu_dec_pkg::M_IXOP: calc_ea = hx + {8'h00, off[7:0]};
			cpu_dec_pkg::M_IX_L: calc_ea = hx + off;
			cpu_dec_pkg::M_STK_S: calc_ea = sp + {8'h00, off[7:0]};
			cpu_dec_pkg::M_STK_L: calc_ea = sp + off;
			default: calc_ea = 16'h0000;
		endcase
	endfunction

	assign in_opc = (st_ff == cpu_dec_pkg::S_OPC);
	assign dec = decode_op(pfx_ff, bus_rdata);
	assign is_pfx = !pfx_ff && (bus_rdata == `OP_PREFIX);
	assign is_xfer = !pfx_ff && (bus_rdata == `OP_XFER_SP);
	assign is_wait = !pfx_ff && (bus_rdata == `OP_WAIT);
	assign is_rts = !pfx_ff && (bus_rdata == `OP_RTS);
	// Never split a prefix from its opcode by an interrupt
	assign irq_take = irq_sync_ff && !imask_ff && !pfx_ff;
	assign dec_cnt = op_bytes(dec.mode, bus_rdata) + {1'b0, dec.rel};
	assign pc_inc = pc_ff + 16'h0001;
	assign rel_sext = {{8{bus_rdata[7]}}, bus_rdata};
	assign cur_mode = in_opc ? dec.mode : mode_ff;
	// Opcode register lags by a cycle when an instruction ends on its opcode fetch
	assign cur_op = in_opc ? bus_rdata : opcode_ff;
	assign cur_pg2 = in_opc ? pfx_ff : page2_ff;
	assign cur_rel = !in_opc && rel_ff;
	assign fin = (in_opc && !irq_take && !is_pfx && !dec.ill && dec_cnt == 2'h0)
		|| (st_ff == cpu_dec_pkg::S_OPR1 && cnt_ff == 2'h1)
		|| (st_ff == cpu_dec_pkg::S_OPR2);
	// Offset byte, when present, is the last byte fetched, or the first when a relative byte follows it
	assign opnd = (st_ff == cpu_dec_pkg::S_OPR2 && !rel_ff) ? {b1_ff, bus_rdata}
		: (st_ff == cpu_dec_pkg::S_OPR2) ? {8'h00, b1_ff} : {8'h00, bus_rdata};
	assign ea_now = calc_ea(cur_mode, opnd, hx_ff, sp_ff);

	always_ff @(posedge sys_clk)
	begin
		irq_meta_ff <= irq_req;
		irq_sync_ff <= irq_meta_ff;
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_pc = pc_ff;
		nxt_addr = bus_addr_ff;
		nxt_cyc = bus_cycle_ff;
		nxt_we = 1'b0;
		nxt_wdata = bus_wdata_ff;
		case (st_ff)
			cpu_dec_pkg::S_OPC, cpu_dec_pkg::S_OPR1, cpu_dec_pkg::S_OPR2:
			begin
				nxt_pc = pc_inc;
				nxt_addr = pc_inc;
				nxt_cyc = cpu_dec_pkg::CYC_FETCH;
				if (in_opc && irq_take)
				begin
					nxt_pc = pc_ff;
					nxt_st = cpu_dec_pkg::S_PUSH_LO;
					nxt_addr = sp_ff;
					nxt_we = 1'b1;
					nxt_wdata = pc_ff[7:0];
					nxt_cyc = cpu_dec_pkg::CYC_PUSH;
				end
				else if (in_opc && (is_pfx || dec.ill))
					nxt_st = cpu_dec_pkg::S_OPC;
				else if (in_opc && (is_xfer || is_wait))
				begin
					nxt_st = cpu_dec_pkg::S_FREE;
					nxt_cyc = cpu_dec_pkg::CYC_FREE;
				end
				else if (in_opc && is_rts)
				begin
					nxt_st = cpu_dec_pkg::S_POP_HI;
					nxt_addr = sp_ff + 16'h0001;
					nxt_cyc = cpu_dec_pkg::CYC_POP;
				end
				else if (in_opc && dec_cnt != 2'h0)
					nxt_st = cpu_dec_pkg::S_OPR1;
				else if (st_ff == cpu_dec_pkg::S_OPR1 && cnt_ff == 2'h2)
					nxt_st = cpu_dec_pkg::S_OPR2;
				else if (fin && is_mem(cur_mode))
				begin
					nxt_st = cpu_dec_pkg::S_ACC;
					nxt_addr = ea_now;
					nxt_cyc = cpu_dec_pkg::CYC_READ;
				end
				else
					nxt_st = cpu_dec_pkg::S_OPC;
			end
			cpu_dec_pkg::S_ACC, cpu_dec_pkg::S_FREE, cpu_dec_pkg::S_POP_LO,
			cpu_dec_pkg::S_VEC_LO:
			begin
				nxt_st = cpu_dec_pkg::S_OPC;
				if (st_ff == cpu_dec_pkg::S_POP_LO || st_ff == cpu_dec_pkg::S_VEC_LO)
					nxt_pc = {hold_hi_ff, bus_rdata};
				nxt_addr = nxt_pc;
				nxt_cyc = cpu_dec_pkg::CYC_FETCH;
				if (st_ff == cpu_dec_pkg::S_FREE && opcode_ff == `OP_WAIT && !page2_ff)
				begin
					nxt_st = cpu_dec_pkg::S_HALT;
					nxt_cyc = cpu_dec_pkg::CYC_FREE;
				end
			end
			cpu_dec_pkg::S_HALT:
				if (irq_sync_ff)
				begin
					nxt_st = cpu_dec_pkg::S_PUSH_LO;
					nxt_addr = sp_ff;
					nxt_we = 1'b1;
					nxt_wdata = pc_ff[7:0];
					nxt_cyc = cpu_dec_pkg::CYC_PUSH;
				end
			cpu_dec_pkg::S_PUSH_LO:
			begin
				nxt_st = cpu_dec_pkg::S_PUSH_HI;
				nxt_addr = sp_ff - 16'h0001;
				nxt_we = 1'b1;
				nxt_wdata = pc_ff[15:8];
			end
			cpu_dec_pkg::S_PUSH_HI:
			begin
				nxt_st = cpu_dec_pkg::S_VEC_HI;
				nxt_addr = {`VEC_PAGE, `VEC_IRQ_LO};
				nxt_cyc = cpu_dec_pkg::CYC_VEC;
			end
			cpu_dec_pkg::S_VEC_HI, cpu_dec_pkg::S_POP_HI:
			begin
				nxt_st = (st_ff == cpu_dec_pkg::S_VEC_HI) ? cpu_dec_pkg::S_VEC_LO
					: cpu_dec_pkg::S_POP_LO;
				nxt_addr = bus_addr_ff + 16'h0001;
			end
			default: nxt_st = cpu_dec_pkg::S_OPC;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			st_ff <= cpu_dec_pkg::S_VEC_HI;
			pc_ff <= `PC_RESET;
			bus_addr_ff <= {`VEC_PAGE, `VEC_RESET_LO};
			bus_cycle_ff <= cpu_dec_pkg::CYC_VEC;
			bus_we_ff <= 1'b0;
			bus_wdata_ff <= 8'h00;
			halted_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			pc_ff <= nxt_pc;
			bus_addr_ff <= nxt_addr;
			bus_cycle_ff <= nxt_cyc;
			bus_we_ff <= nxt_we;
			bus_wdata_ff <= nxt_wdata;
			halted_ff <= (nxt_st == cpu_dec_pkg::S_HALT);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			opcode_ff <= 8'h00;
			page2_ff <= 1'b0;
			pfx_ff <= 1'b0;
			mode_ff <= cpu_dec_pkg::M_NONE;
			rel_ff <= 1'b0;
			cnt_ff <= 2'h0;
			b1_ff <= 8'h00;
			hold_hi_ff <= 8'h00;
			illegal_ff <= 1'b0;
		end
		else
		begin
			illegal_ff <= in_opc && !irq_take && !is_pfx && dec.ill;
			if (in_opc && !irq_take)
			begin
				pfx_ff <= is_pfx;
				if (!is_pfx)
				begin
					opcode_ff <= bus_rdata;
					page2_ff <= pfx_ff;
					mode_ff <= dec.mode;
					rel_ff <= dec.rel;
					cnt_ff <= dec_cnt;
				end
			end
			if (st_ff == cpu_dec_pkg::S_OPR1)
				b1_ff <= bus_rdata;
			if (st_ff == cpu_dec_pkg::S_VEC_HI || st_ff == cpu_dec_pkg::S_POP_HI)
				hold_hi_ff <= bus_rdata;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ea_ff <= 16'h0000;
			ea_valid_ff <= 1'b0;
			imm_ff <= 16'h0000;
			imm_valid_ff <= 1'b0;
			branch_target_ff <= 16'h0000;
			branch_valid_ff <= 1'b0;
			bit_num_ff <= 3'h0;
			bit_valid_ff <= 1'b0;
			data_ff <= 8'h00;
			data_valid_ff <= 1'b0;
		end
		else
		begin
			ea_valid_ff <= fin && is_mem(cur_mode);
			imm_valid_ff <= fin && (cur_mode inside {cpu_dec_pkg::M_IMM8, cpu_dec_pkg::M_IMM16});
			branch_valid_ff <= fin && cur_rel;
			bit_valid_ff <= fin && !cur_pg2 && (cur_op[7:5] == 3'h0);
			data_valid_ff <= (st_ff == cpu_dec_pkg::S_ACC);
			if (fin)
			begin
				ea_ff <= ea_now;
				imm_ff <= opnd;
				branch_target_ff <= pc_inc + rel_sext;
				bit_num_ff <= cur_op[3:1];
			end
			if (st_ff == cpu_dec_pkg::S_ACC)
				data_ff <= bus_rdata;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			sp_ff <= SP_INIT;
		else if (st_ff == cpu_dec_pkg::S_FREE && opcode_ff == `OP_XFER_SP && !page2_ff)
			sp_ff <= hx_ff - 16'h0001;
		else if (st_ff inside {cpu_dec_pkg::S_PUSH_LO, cpu_dec_pkg::S_PUSH_HI})
			sp_ff <= sp_ff - 16'h0001;
		else if (st_ff inside {cpu_dec_pkg::S_POP_HI, cpu_dec_pkg::S_POP_LO})
			sp_ff <= sp_ff + 16'h0001;
	end

	// Post-increment wins over a datapath load in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			hx_ff <= `HX_RESET;
		else if (fin && (cur_mode inside {cpu_dec_pkg::M_IXP, cpu_dec_pkg::M_IXOP}))
			hx_ff <= hx_ff + 16'h0001;
		else if (hx_load)
			hx_ff <= hx_value;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			imask_ff <= 1'b1;
		else if (st_ff == cpu_dec_pkg::S_FREE && opcode_ff == `OP_WAIT && !page2_ff)
			imask_ff <= 1'b0;
		else if (st_ff == cpu_dec_pkg::S_VEC_LO)
			imask_ff <= 1'b1;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	xfer_sp_load_a: assert property ((st_ff == cpu_dec_pkg::S_FREE) && opcode_ff == `OP_XFER_SP
		&& !page2_ff |=> sp_ff == $past(hx_ff) - 16'h0001 && in_opc)
		else $error("sp not loaded from index minus one");
	xfer_cycles_a: assert property (in_opc && !irq_take && is_xfer
		|=> bus_cycle_ff == cpu_dec_pkg::CYC_FREE ##1 bus_cycle_ff == cpu_dec_pkg::CYC_FETCH)
		else $error("transfer not free then fetch");
	wait_halt_a: assert property ((st_ff == cpu_dec_pkg::S_FREE) && opcode_ff == `OP_WAIT
		&& !page2_ff |=> halted_ff && !imask_ff)
		else $error("wait did not halt with mask clear");
	free_cycle_a: assert property ((st_ff == cpu_dec_pkg::S_FREE)
		|-> !bus_we_ff ##1 st_ff != cpu_dec_pkg::S_FREE)
		else $error("free cycle wrong");
	fetch_next_a: assert property (bus_cycle_ff == cpu_dec_pkg::CYC_FETCH
		&& $past(bus_cycle_ff) == cpu_dec_pkg::CYC_FETCH |-> bus_addr_ff == $past(bus_addr_ff) + 16'h0001)
		else $error("fetch not consecutive");
	push_one_a: assert property ((st_ff inside {cpu_dec_pkg::S_PUSH_LO, cpu_dec_pkg::S_PUSH_HI})
		|-> bus_we_ff && bus_addr_ff == sp_ff ##1 sp_ff == $past(sp_ff) - 16'h0001)
		else $error("push not one byte");
	vector_order_a: assert property ((st_ff == cpu_dec_pkg::S_VEC_HI)
		|-> bus_addr_ff[15:8] == `VEC_PAGE ##1 (st_ff == cpu_dec_pkg::S_VEC_LO)
		&& bus_addr_ff == $past(bus_addr_ff) + 16'h0001)
		else $error("vector order wrong");
	branch_target_a: assert property (branch_valid_ff
		|-> branch_target_ff == $past(bus_addr_ff) + 16'h0001
		+ {{8{$past(bus_rdata[7])}}, $past(bus_rdata)})
		else $error("branch target wrong");
	direct_page_a: assert property (ea_valid_ff && mode_ff == cpu_dec_pkg::M_DIR
		|-> ea_ff[15:8] == 8'h00)
		else $error("direct address off page zero");
	post_inc_a: assert property (ea_valid_ff
		&& (mode_ff inside {cpu_dec_pkg::M_IXP, cpu_dec_pkg::M_IXOP})
		|-> hx_ff == $past(hx_ff) + 16'h0001)
		else $error("index not incremented");
	illegal_flag_a: assert property (in_opc && !irq_take && pfx_ff && bus_rdata == 8'h62
		|=> illegal_ff)
		else $error("illegal second table opcode not flagged");

	xfer_seen_c: cover property (in_opc && !irq_take && is_xfer ##2 in_opc);
	wait_wake_c: cover property (halted_ff ##1 st_ff == cpu_dec_pkg::S_PUSH_LO);
	stack_long_c: cover property (ea_valid_ff && mode_ff == cpu_dec_pkg::M_STK_L);

endmodule // opcode_sequencer

/* File: sim/prog_memory.sv */
// Zero-wait program and data memory model for the system bus
`timescale 1ns/1ps
module prog_memory (
	// Clock
	input wire logic sys_clk,
	// System bus
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_we,
	output logic [7:0] bus_rdata
);
	logic [7:0] mem [0:65535];

	// Filled with no-op so a core running ahead never meets stale code
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h9d;
	end

	// Same-cycle read, no wait states
	assign bus_rdata = mem[bus_addr];

	// Plain always: the bench also loads code into this array
	always @(posedge sys_clk)
	begin
		if (bus_we === 1'b1)
			mem[bus_addr] <= bus_wdata;
	end
endmodule // prog_memory

/* File: sim/tb_top.sv */
// Self-checking bench for the opcode decoder and bus-cycle sequencer
`timescale 1ns/1ps
module tb_top;
	logic sys_clk;
	logic reset;
	logic [7:0] bus_rdata, bus_wdata_ff, opcode_ff, data_ff, got_data;
	logic [15:0] bus_addr_ff, hx_value, ea_ff, imm_ff, branch_target_ff, hx_ff, sp_ff;
	logic bus_we_ff, irq_req, hx_load, page2_ff, ea_valid_ff, imm_valid_ff;
	logic branch_valid_ff, bit_valid_ff, data_valid_ff, illegal_ff, halted_ff, imask_ff;
	logic [2:0] bit_num_ff, got_bit;
	cpu_dec_pkg::cycle_t bus_cycle_ff;
	cpu_dec_pkg::mode_t mode_ff;
	int fail_count, num_checks;
	logic [15:0] ia, ret, got_ea, got_imm, got_br;
	logic got_ill, got_p2;

	opcode_sequencer i_opcode_sequencer (
		.sys_clk(sys_clk), .reset(reset), .bus_rdata(bus_rdata),
		.bus_addr_ff(bus_addr_ff), .bus_wdata_ff(bus_wdata_ff), .bus_we_ff(bus_we_ff),
		.bus_cycle_ff(bus_cycle_ff), .irq_req(irq_req), .hx_load(hx_load),
		.hx_value(hx_value), .opcode_ff(opcode_ff), .page2_ff(page2_ff),
		.mode_ff(mode_ff), .ea_ff(ea_ff), .ea_valid_ff(ea_valid_ff), .imm_ff(imm_ff),
		.imm_valid_ff(imm_valid_ff), .branch_target_ff(branch_target_ff),
		.branch_valid_ff(branch_valid_ff), .bit_num_ff(bit_num_ff),
		.bit_valid_ff(bit_valid_ff), .data_ff(data_ff), .data_valid_ff(data_valid_ff),
		.illegal_ff(illegal_ff), .halted_ff(halted_ff), .imask_ff(imask_ff),
		.hx_ff(hx_ff), .sp_ff(sp_ff)
	);

	prog_memory i_prog_memory (
		.sys_clk(sys_clk), .bus_addr(bus_addr_ff), .bus_wdata(bus_wdata_ff),
		.bus_we(bus_we_ff), .bus_rdata(bus_rdata)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Pulses last one cycle, so every step latches what it saw
	task automatic step();
		@(posedge sys_clk);
		#1;
		if (ea_valid_ff === 1'b1)
		begin
			got_ea = ea_ff;
			got_p2 = page2_ff;
		end
		if (imm_valid_ff === 1'b1)
			got_imm = imm_ff;
		if (branch_valid_ff === 1'b1)
			got_br = branch_target_ff;
		if (bit_valid_ff === 1'b1)
			got_bit = bit_num_ff;
		if (data_valid_ff === 1'b1)
			got_data = data_ff;
		if (illegal_ff === 1'b1)
			got_ill = 1'b1;
	endtask

	task automatic bus_is(input cpu_dec_pkg::cycle_t c, input logic [15:0] a);
		check(16'(bus_cycle_ff), 16'(c));
		check(bus_addr_ff, a);
	endtask

	// Places code ahead of the running core and waits for its opcode fetch
	task automatic start(input logic [7:0] b0, b1, b2, b3);
		int k;
		ia = bus_addr_ff + 16'h0010;
		i_prog_memory.mem[ia] = b0;
		i_prog_memory.mem[ia + 16'h0001] = b1;
		i_prog_memory.mem[ia + 16'h0002] = b2;
		i_prog_memory.mem[ia + 16'h0003] = b3;
		k = 0;
		while (k < 60 && !(bus_cycle_ff === cpu_dec_pkg::CYC_FETCH && bus_addr_ff === ia))
		begin
			step();
			k++;
		end
		check(bus_addr_ff, ia);
		got_ea = 16'hxxxx;
		got_imm = 16'hxxxx;
		got_br = 16'hxxxx;
		got_bit = 3'hx;
		got_data = 8'hxx;
		got_p2 = 1'bx;
		got_ill = 1'b0;
	endtask

	// Restores no-ops so a later backward branch cannot rerun this code
	task automatic exec(input logic [7:0] b0, b1, b2, b3, input int n);
		start(b0, b1, b2, b3);
		repeat (n) step();
		for (int k = 0; k < 4; k++)
			i_prog_memory.mem[ia + 16'(k)] = 8'h9d;
	endtask

	task automatic load_index(input logic [15:0] v);
		hx_load = 1'b1;
		hx_value = v;
		step();
		hx_load = 1'b0;
	endtask

	task automatic t_reset();
		bus_is(cpu_dec_pkg::CYC_VEC, 16'hfffe);
		reset = 1'b0;
		step();
		bus_is(cpu_dec_pkg::CYC_VEC, 16'hffff);
		step();
		bus_is(cpu_dec_pkg::CYC_FETCH, 16'h0100);
		$display("reset vector test done");
	endtask

	task automatic t_xfer();
		load_index(16'h0091);
		start(8'h94, 8'h9d, 8'h9d, 8'h9d);
		step();
		bus_is(cpu_dec_pkg::CYC_FREE, ia + 16'h0001);
		check(bus_we_ff, 1'b0);
		step();
		bus_is(cpu_dec_pkg::CYC_FETCH, ia + 16'h0001);
		check(sp_ff, 16'h0090);
		$display("index to stack transfer test done");
	endtask

	task automatic t_rts();
		ret = bus_addr_ff + 16'h0040;
		i_prog_memory.mem[16'h0091] = ret[15:8];
		i_prog_memory.mem[16'h0092] = ret[7:0];
		start(8'h81, 8'h9d, 8'h9d, 8'h9d);
		step();
		bus_is(cpu_dec_pkg::CYC_POP, 16'h0091);
		check(bus_we_ff, 1'b0);
		step();
		bus_is(cpu_dec_pkg::CYC_POP, 16'h0092);
		step();
		bus_is(cpu_dec_pkg::CYC_FETCH, ret);
		$display("return pop test done");
	endtask

	task automatic t_wait();
		int k;
		start(8'h8f, 8'h9d, 8'h9d, 8'h9d);
		ret = ia + 16'h0001;
		step();
		check(16'(bus_cycle_ff), 16'(cpu_dec_pkg::CYC_FREE));
		repeat (4) step();
		check(halted_ff, 1'b1);
		check(imask_ff, 1'b0);
		check(16'(bus_cycle_ff), 16'(cpu_dec_pkg::CYC_FREE));
		irq_req = 1'b1;
		k = 0;
		while (k < 8 && bus_cycle_ff !== cpu_dec_pkg::CYC_PUSH)
		begin
			step();
			k++;
		end
		irq_req = 1'b0;
		bus_is(cpu_dec_pkg::CYC_PUSH, 16'h0092);
		check(bus_wdata_ff, ret[7:0]);
		check(bus_we_ff, 1'b1);
		step();
		bus_is(cpu_dec_pkg::CYC_PUSH, 16'h0091);
		check(bus_wdata_ff, ret[15:8]);
		step();
		bus_is(cpu_dec_pkg::CYC_VEC, 16'hfffa);
		step();
		bus_is(cpu_dec_pkg::CYC_VEC, 16'hfffb);
		step();
		bus_is(cpu_dec_pkg::CYC_FETCH, 16'h0200);
		$display("wait and interrupt test done");
	endtask

	task automatic t_modes();
		i_prog_memory.mem[16'h0040] = 8'h5a;
		exec(8'hb6, 8'h40, 8'h9d, 8'h9d, 5);
		check(got_ea, 16'h0040);
		check(got_data, 8'h5a);
		check(got_ill, 1'b0);
		load_index(16'h1234);
		exec(8'h71, 8'h05, 8'h9d, 8'h9d, 5);
		check(got_ea, 16'h1234);
		check(hx_ff, 16'h1235);
		exec(8'he6, 8'h80, 8'h9d, 8'h9d, 5);
		check(got_ea, 16'h12b5);
		exec(8'hd6, 8'h80, 8'h00, 8'h9d, 6);
		check(got_ea, 16'h9235);
		exec(8'hc6, 8'h12, 8'h34, 8'h9d, 6);
		check(got_ea, 16'h1234);
		exec(8'hf6, 8'h9d, 8'h9d, 8'h9d, 4);
		check(got_ea, 16'h1235);
		exec(8'h61, 8'h10, 8'h05, 8'h9d, 6);
		check(got_ea, 16'h1245);
		check(hx_ff, 16'h1236);
		exec(8'h4e, 8'h40, 8'h41, 8'h9d, 3);
		bus_is(cpu_dec_pkg::CYC_FETCH, ia + 16'h0003);
		check(opcode_ff, 8'h4e);
		check(16'(mode_ff), 16'(cpu_dec_pkg::M_MOVE));
		exec(8'h9e, 8'he6, 8'h10, 8'h9d, 6);
		check(got_ea, 16'h00a0);
		check(got_p2, 1'b1);
		exec(8'h9e, 8'hd6, 8'h01, 8'h00, 7);
		check(got_ea, 16'h0190);
		$display("addressing mode test done");
	endtask

	task automatic t_operands();
		exec(8'ha6, 8'hc3, 8'h9d, 8'h9d, 4);
		check(got_imm, 16'h00c3);
		exec(8'h65, 8'h12, 8'h34, 8'h9d, 5);
		check(got_imm, 16'h1234);
		exec(8'h20, 8'h7f, 8'h9d, 8'h9d, 4);
		check(got_br, ia + 16'h0081);
		exec(8'h20, 8'h80, 8'h9d, 8'h9d, 4);
		check(got_br, ia - 16'h007e);
		exec(8'h14, 8'h40, 8'h9d, 8'h9d, 5);
		check(got_bit, 3'h2);
		exec(8'h0f, 8'h40, 8'h05, 8'h9d, 6);
		check(got_bit, 3'h7);
		exec(8'h8d, 8'h9d, 8'h9d, 8'h9d, 3);
		check(got_ill, 1'b1);
		exec(8'h9e, 8'h00, 8'h9d, 8'h9d, 4);
		check(got_ill, 1'b1);
		exec(8'h9e, 8'h62, 8'h9d, 8'h9d, 4);
		check(got_ill, 1'b1);
		$display("operand and illegal test done");
	endtask

	initial
	begin
		reset = 1'b1;
		irq_req = 1'b0;
		hx_load = 1'b0;
		hx_value = 16'h0000;
		fail_count = 0;
		num_checks = 0;
		repeat (10) step();
		i_prog_memory.mem[16'hfffe] = 8'h01;
		i_prog_memory.mem[16'hffff] = 8'h00;
		i_prog_memory.mem[16'hfffa] = 8'h02;
		i_prog_memory.mem[16'hfffb] = 8'h00;
		t_reset();
		t_xfer();
		t_rts();
		t_wait();
		t_modes();
		t_operands();
		give_verdict();
	end

	// Whole run is about five hundred cycles
	initial
	begin
		#50000;
		fail_count++;
		give_verdict();
	end
endmodule // tb_top
